// ===== rtl/dtc_defines.vh
// Constants for the dual timer/counter pair (third and fourth timers).
// Assumes an APB slave with 32-bit data, one register per aligned word.
//
// Overview of operation
// - Timer C select bit picks sub oscillator
// - Timer D select bit picks sub oscillator
// - Oscillator select bits are write-only
// - Gate: run bit and gate pin high
// - Counter select: internal clock or pin events
// - Mode 00 13-bit, mode 01 16-bit
// - Mode 10 8-bit auto-reload from high byte
// - Mode 11 splits timer C, stops D
`ifndef DTC_DEFINES_VH
`define DTC_DEFINES_VH

// ----------------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------------
`define DTC_ADDR_CONTROL 12'h000
`define DTC_ADDR_MODE 12'h004
`define DTC_ADDR_C_LOW 12'h008
`define DTC_ADDR_C_HIGH 12'h00c
`define DTC_ADDR_D_LOW 12'h010
`define DTC_ADDR_D_HIGH 12'h014
`define DTC_ADDR_STATUS 12'h018
`define DTC_ADDR_MASK 12'h01c

// ----------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------
`define DTC_CTL_D_FLAG 7
`define DTC_CTL_D_RUN 6
`define DTC_CTL_C_FLAG 5
`define DTC_CTL_C_RUN 4
`define DTC_CTL_C_SUB 3
`define DTC_CTL_D_SUB 0

// ----------------------------------------------------------------------
// Mode register fields, per timer nibble
// ----------------------------------------------------------------------
`define DTC_MOD_GATE 3
`define DTC_MOD_CNT 2
`define DTC_MOD_M1 1
`define DTC_MOD_M0 0
`define DTC_MODE_13 2'b00
`define DTC_MODE_16 2'b01
`define DTC_MODE_RELOAD 2'b10
`define DTC_MODE_SPLIT 2'b11

// ----------------------------------------------------------------------
// Reset values and status bits
// ----------------------------------------------------------------------
`define DTC_RST_BYTE 8'h00
`define DTC_STS_C 0
`define DTC_STS_D 1
`define DTC_STS_C_HIGH 2

`endif

// ===== rtl/dtc_tick_gen.v
// Count-enable generator for one timer of the pair.
// Assumes pins and oscillator ticks come from outside the clock domain.
`timescale 1ns/1ps

module dtc_tick_gen (
	clock,
	rst,
	main_tick,
	sub_tick,
	count_pin,
	gate_pin,
	sub_select,
	counter_select,
	gate_enable,
	run_bit,
	tick_timer,
	tick_any
);
	input wire clock;
	input wire rst;
	input wire main_tick;
	input wire sub_tick;
	input wire count_pin;
	input wire gate_pin;
	input wire sub_select;
	input wire counter_select;
	input wire gate_enable;
	input wire run_bit;
	output wire tick_timer;
	output wire tick_any;

	// ------------------------------------------------------------------
	// Two-flop synchronisers, third stage for edge detection
	// ------------------------------------------------------------------
	reg [1:0] sync_a_reg;
	reg [1:0] sync_b_reg;
	reg [1:0] sync_p_reg;
	reg [1:0] sync_g_reg;
	reg main_old_reg;
	reg sub_old_reg;
	reg pin_old_reg;
	wire main_rise;
	wire sub_rise;
	wire pin_fall;
	wire enabled;
	wire timer_tick;

	// Sampling only; first flop feeds nothing but the second
	always @(posedge clock) begin
		if (rst) begin
			sync_a_reg <= 2'h0;
			sync_b_reg <= 2'h0;
			sync_p_reg <= 2'h3;
			sync_g_reg <= 2'h0;
			main_old_reg <= 1'b0;
			sub_old_reg <= 1'b0;
			pin_old_reg <= 1'b1;
		end else begin
			sync_a_reg <= {sync_a_reg[0], main_tick};
			sync_b_reg <= {sync_b_reg[0], sub_tick};
			sync_p_reg <= {sync_p_reg[0], count_pin};
			sync_g_reg <= {sync_g_reg[0], gate_pin};
			main_old_reg <= sync_a_reg[1];
			sub_old_reg <= sync_b_reg[1];
			pin_old_reg <= sync_p_reg[1];
		end
	end

	assign main_rise = sync_a_reg[1] & ~main_old_reg;
	assign sub_rise = sync_b_reg[1] & ~sub_old_reg;
	// Counter input counts falling events on the pin
	assign pin_fall = ~sync_p_reg[1] & pin_old_reg;

	// Oscillator choice: 1 picks sub, 0 picks main
	assign timer_tick = sub_select ? sub_rise : main_rise;
	// Gate needs the pin high as well as the run bit
	assign enabled = run_bit & (~gate_enable | sync_g_reg[1]);
	// Timer or counter source
	assign tick_any = enabled & (counter_select ? pin_fall : timer_tick);
	// Internal-clock-only tick, ignoring the counter select
	assign tick_timer = run_bit & timer_tick;
endmodule // dtc_tick_gen

// ===== rtl/dtc_timer_pair.v
// Dual timer/counter (third and fourth timers) with an APB slave.
// Assumes oscillator ticks, count pins and gate pins are asynchronous.
//
// Added by the designer: the APB register port and the register offsets.
`timescale 1ns/1ps
`include "dtc_defines.vh"

module dtc_timer_pair (
	clock,
	rst,
	psel,
	penable,
	pwrite,
	paddr,
	pwdata,
	prdata,
	pready,
	pslverr,
	main_osc_tick,
	sub_osc_tick,
	timer_c_count_pin,
	timer_d_count_pin,
	timer_c_gate_pin,
	timer_d_gate_pin,
	timer_c_vector_ack,
	timer_d_vector_ack,
	timer_c_overflow_flag,
	timer_d_overflow_flag,
	irq
);
	input wire clock;
	input wire rst;
	input wire psel;
	input wire penable;
	input wire pwrite;
	input wire [11:0] paddr;
	input wire [31:0] pwdata;
	output reg [31:0] prdata;
	output wire pready;
	output wire pslverr;
	input wire main_osc_tick;
	input wire sub_osc_tick;
	input wire timer_c_count_pin;
	input wire timer_d_count_pin;
	input wire timer_c_gate_pin;
	input wire timer_d_gate_pin;
	input wire timer_c_vector_ack;
	input wire timer_d_vector_ack;
	output wire timer_c_overflow_flag;
	output wire timer_d_overflow_flag;
	output wire irq;

	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------
	reg timer_c_run_reg;
	reg timer_d_run_reg;
	reg timer_c_sub_osc_select_reg;
	reg timer_d_sub_osc_select_reg;
	reg timer_c_flag_reg;
	reg timer_d_flag_reg;
	reg [7:0] mode_reg;
	reg [7:0] c_low_reg;
	reg [7:0] c_high_reg;
	reg [7:0] d_low_reg;
	reg [7:0] d_high_reg;
	reg [2:0] status_reg;
	reg [2:0] mask_reg;
	reg [7:0] c_low_next;
	reg [7:0] c_high_next;
	reg [7:0] d_low_next;
	reg [7:0] d_high_next;
	reg c_ovf;
	reg d_ovf;
	reg c_high_ovf;
	reg [31:0] read_next;

	wire c_tick;
	wire c_tick_timer;
	wire d_tick;
	wire d_tick_timer;
	wire [3:0] c_mode_bits;
	wire [3:0] d_mode_bits;
	wire [1:0] c_mode;
	wire [1:0] d_mode;
	wire wr_en;
	wire rd_en;
	wire addr_ok;
	wire [2:0] events;

	assign c_mode_bits = mode_reg[3:0];
	assign d_mode_bits = mode_reg[7:4];
	assign c_mode = {c_mode_bits[`DTC_MOD_M1], c_mode_bits[`DTC_MOD_M0]};
	assign d_mode = {d_mode_bits[`DTC_MOD_M1], d_mode_bits[`DTC_MOD_M0]};

	// ------------------------------------------------------------------
	// Count enables for both timers
	// ------------------------------------------------------------------
	dtc_tick_gen u_tick_c (
		.clock(clock),
		.rst(rst),
		.main_tick(main_osc_tick),
		.sub_tick(sub_osc_tick),
		.count_pin(timer_c_count_pin),
		.gate_pin(timer_c_gate_pin),
		.sub_select(timer_c_sub_osc_select_reg),
		.counter_select(c_mode_bits[`DTC_MOD_CNT]),
		.gate_enable(c_mode_bits[`DTC_MOD_GATE]),
		.run_bit(timer_c_run_reg),
		.tick_timer(c_tick_timer),
		.tick_any(c_tick)
	);

	dtc_tick_gen u_tick_d (
		.clock(clock),
		.rst(rst),
		.main_tick(main_osc_tick),
		.sub_tick(sub_osc_tick),
		.count_pin(timer_d_count_pin),
		.gate_pin(timer_d_gate_pin),
		.sub_select(timer_d_sub_osc_select_reg),
		.counter_select(d_mode_bits[`DTC_MOD_CNT]),
		.gate_enable(d_mode_bits[`DTC_MOD_GATE]),
		.run_bit(timer_d_run_reg),
		.tick_timer(d_tick_timer),
		.tick_any(d_tick)
	);

	// ------------------------------------------------------------------
	// Counting function shared by both timers, all four modes for C, modes 00 to 10 for D (11 counts the low byte only)
	// Returns {overflow, high, low}
	// ------------------------------------------------------------------
	function [16:0] dtc_step;
		input [1:0] mode;
		input [7:0] high;
		input [7:0] low;
		reg [13:0] v13;
		reg [16:0] v16;
		reg [8:0] v8;
		begin
			v13 = 14'h0000;
			v16 = 17'h00000;
			v8 = 9'h000;
			case (mode)
			`DTC_MODE_13: begin
				// 5-bit prescaler in low byte, 8 bits in high
				v13 = {1'b0, high, low[4:0]} + 14'h0001;
				dtc_step = {v13[13], v13[12:5], low[7:5], v13[4:0]};
			end
			`DTC_MODE_16: begin
				// High and low cascaded, no prescaler
				v16 = {1'b0, high, low} + 17'h00001;
				dtc_step = v16;
			end
			`DTC_MODE_RELOAD: begin
				// Low byte reloads from high byte on overflow
				v8 = {1'b0, low} + 9'h001;
				if (v8[8])
					dtc_step = {1'b1, high, high};
				else
					dtc_step = {1'b0, high, v8[7:0]};
			end
			default: begin
				v8 = {1'b0, low} + 9'h001;
				dtc_step = {v8[8], high, v8[7:0]};
			end
			endcase
		end
	endfunction

	// ------------------------------------------------------------------
	// Next count values
	// ------------------------------------------------------------------
	always @* begin
		{c_ovf, c_high_next, c_low_next} =
			{1'b0, c_high_reg, c_low_reg};
		{d_ovf, d_high_next, d_low_next} =
			{1'b0, d_high_reg, d_low_reg};
		c_high_ovf = 1'b0;
		// Timer C: low byte uses its own bits in split mode
		if (c_tick)
			{c_ovf, c_high_next, c_low_next} =
				dtc_step(c_mode, c_high_reg, c_low_reg);
		if (c_mode == `DTC_MODE_SPLIT) begin
			c_high_next = c_high_reg;
			// High byte is a timer run by timer D's run bit
			if (d_tick_timer)
				{c_high_ovf, c_high_next} = {1'b0, c_high_reg} + 9'h001;
		end
		// Timer D stops in mode 11
		if (d_tick && d_mode != `DTC_MODE_SPLIT)
			{d_ovf, d_high_next, d_low_next} =
				dtc_step(d_mode, d_high_reg, d_low_reg);
	end

	// ------------------------------------------------------------------
	// APB decode; zero wait states, unmapped addresses raise pslverr
	// ------------------------------------------------------------------
	assign addr_ok = (paddr == `DTC_ADDR_CONTROL) ||
		(paddr == `DTC_ADDR_MODE) || (paddr == `DTC_ADDR_C_LOW) ||
		(paddr == `DTC_ADDR_C_HIGH) || (paddr == `DTC_ADDR_D_LOW) ||
		(paddr == `DTC_ADDR_D_HIGH) || (paddr == `DTC_ADDR_STATUS) ||
		(paddr == `DTC_ADDR_MASK);
	assign pready = 1'b1;
	assign pslverr = psel & penable & ~addr_ok;
	assign wr_en = psel & penable & pwrite & addr_ok;
	assign rd_en = psel & penable & ~pwrite & addr_ok;

	// Split-mode overflow of timer C's high byte raises timer D's flag
	assign events = {c_high_ovf, d_ovf | c_high_ovf, c_ovf};

	// ------------------------------------------------------------------
	// Register and counter updates
	// ------------------------------------------------------------------
	always @(posedge clock) begin
		if (rst) begin
			timer_c_run_reg <= 1'b0;
			timer_d_run_reg <= 1'b0;
			timer_c_sub_osc_select_reg <= 1'b0;
			timer_d_sub_osc_select_reg <= 1'b0;
			timer_c_flag_reg <= 1'b0;
			timer_d_flag_reg <= 1'b0;
			mode_reg <= `DTC_RST_BYTE;
			c_low_reg <= `DTC_RST_BYTE;
			c_high_reg <= `DTC_RST_BYTE;
			d_low_reg <= `DTC_RST_BYTE;
			d_high_reg <= `DTC_RST_BYTE;
			status_reg <= 3'h0;
			mask_reg <= 3'h0;
		end else begin
			c_low_reg <= c_low_next;
			c_high_reg <= c_high_next;
			d_low_reg <= d_low_next;
			d_high_reg <= d_high_next;
			// Rollover sets, vector clears; set wins the tie
			if (events[`DTC_STS_C])
				timer_c_flag_reg <= 1'b1;
			else if (timer_c_vector_ack)
				timer_c_flag_reg <= 1'b0;
			if (events[`DTC_STS_D])
				timer_d_flag_reg <= 1'b1;
			else if (timer_d_vector_ack)
				timer_d_flag_reg <= 1'b0;
			// Sticky status, cleared by reading it; new event wins
			if (rd_en && paddr == `DTC_ADDR_STATUS)
				status_reg <= events;
			else
				status_reg <= status_reg | events;
			if (wr_en) begin
				case (paddr)
				`DTC_ADDR_CONTROL: begin
					// Software starts and stops the timers
					timer_c_run_reg <= pwdata[`DTC_CTL_C_RUN];
					timer_d_run_reg <= pwdata[`DTC_CTL_D_RUN];
					timer_c_sub_osc_select_reg <= pwdata[`DTC_CTL_C_SUB];
					timer_d_sub_osc_select_reg <= pwdata[`DTC_CTL_D_SUB];
					// Flags writable by software unless a rollover hits
					if (!events[`DTC_STS_C])
						timer_c_flag_reg <= pwdata[`DTC_CTL_C_FLAG];
					if (!events[`DTC_STS_D])
						timer_d_flag_reg <= pwdata[`DTC_CTL_D_FLAG];
				end
				`DTC_ADDR_MODE: mode_reg <= pwdata[7:0];
				`DTC_ADDR_C_LOW: c_low_reg <= pwdata[7:0];
				`DTC_ADDR_C_HIGH: c_high_reg <= pwdata[7:0];
				`DTC_ADDR_D_LOW: d_low_reg <= pwdata[7:0];
				`DTC_ADDR_D_HIGH: d_high_reg <= pwdata[7:0];
				`DTC_ADDR_MASK: mask_reg <= pwdata[2:0];
				default: mask_reg <= mask_reg;
				endcase
			end
		end
	end

	// ------------------------------------------------------------------
	// Read data; select bits read as zero since they are write-only
	// ------------------------------------------------------------------
	always @* begin
		read_next = 32'h00000000;
		case (paddr)
		`DTC_ADDR_CONTROL: begin
			read_next[`DTC_CTL_D_FLAG] = timer_d_flag_reg;
			read_next[`DTC_CTL_D_RUN] = timer_d_run_reg;
			read_next[`DTC_CTL_C_FLAG] = timer_c_flag_reg;
			read_next[`DTC_CTL_C_RUN] = timer_c_run_reg;
		end
		`DTC_ADDR_MODE: read_next[7:0] = mode_reg;
		`DTC_ADDR_C_LOW: read_next[7:0] = c_low_reg;
		`DTC_ADDR_C_HIGH: read_next[7:0] = c_high_reg;
		`DTC_ADDR_D_LOW: read_next[7:0] = d_low_reg;
		`DTC_ADDR_D_HIGH: read_next[7:0] = d_high_reg;
		`DTC_ADDR_STATUS: read_next[2:0] = status_reg;
		`DTC_ADDR_MASK: read_next[2:0] = mask_reg;
		default: read_next = 32'h00000000;
		endcase
	end

	// Registered read data, loaded in the setup cycle
	always @(posedge clock) begin
		if (rst)
			prdata <= 32'h00000000;
		else if (psel && !penable && !pwrite)
			prdata <= read_next;
	end

	assign timer_c_overflow_flag = timer_c_flag_reg;
	assign timer_d_overflow_flag = timer_d_flag_reg;
	// Level interrupt while any unmasked status bit is set
	assign irq = |(status_reg & mask_reg);
endmodule // dtc_timer_pair

// ===== test/dtc_timer_pair_props.sv
// Port-level checks for the timer pair: APB answers and overflow flags.
// Assumes binding into dtc_timer_pair; one clock, rst synchronous high.
`timescale 1ns/1ps
`include "dtc_defines.vh"

module dtc_timer_pair_props (
	input wire clock,
	input wire rst,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] prdata,
	input wire pready,
	input wire pslverr,
	input wire timer_c_vector_ack,
	input wire timer_d_vector_ack,
	input wire timer_c_overflow_flag,
	input wire timer_d_overflow_flag,
	input wire irq
);
	// ------------------------------------------------------------
	// Access decode seen from the bus
	// ------------------------------------------------------------
	wire acc = psel && penable;
	wire wr_acc = acc && pwrite;
	// Unmapped: past the last word, or not on a word boundary
	wire bad = (paddr > `DTC_ADDR_MASK) || (paddr[1:0] != 2'h0);
	wire at_ctl = paddr == `DTC_ADDR_CONTROL;

	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);

	// Read access, and a vector taken while the flag is up
	sequence s_rd;
		acc && !pwrite;
	endsequence
	sequence s_ack_c;
		timer_c_vector_ack && timer_c_overflow_flag;
	endsequence
	sequence s_ack_d;
		timer_d_vector_ack && timer_d_overflow_flag;
	endsequence

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	AST_READY: assert property (pready) else $error("pready low");
	AST_ERR_SET: assert property (acc && bad |-> pslverr)
		else $error("no error on unmapped access");
	AST_ERR_ONLY: assert property (pslverr |-> acc && bad)
		else $error("stray error response");
	AST_ERR_DATA: assert property (s_rd ##0 bad |-> prdata == 32'h0)
		else $error("unmapped read not zero");
	AST_UPPER: assert property (s_rd |-> prdata[31:8] == 24'h0)
		else $error("upper read bits not zero");
	AST_SUB_WO: assert property (s_rd ##0 at_ctl |->
		!prdata[`DTC_CTL_C_SUB] && !prdata[`DTC_CTL_D_SUB])
		else $error("select bits read back");
	// Flags must already be clear on the first edge out of reset
	AST_RST_CLR: assert property ($fell(rst) |->
		!timer_c_overflow_flag && !timer_d_overflow_flag && !irq)
		else $error("flags set after reset");
	AST_ACK_C: assert property (s_ack_c |=> !timer_c_overflow_flag)
		else $error("vector did not clear flag c");
	AST_ACK_D: assert property (s_ack_d |=> !timer_d_overflow_flag)
		else $error("vector did not clear flag d");
	// Flag C may only drop through a vector, a write or reset
	AST_FELL_C: assert property ($fell(timer_c_overflow_flag) |->
		$past(timer_c_vector_ack) || $past(wr_acc) || $past(rst))
		else $error("flag c dropped without cause");
endmodule // dtc_timer_pair_props

// ===== test/tb_top.sv
// Self-checking bench for the timer pair, driven over APB.
// Assumes the zero-wait slave and one 10 MHz clock.
`timescale 1ns/1ps
`include "dtc_defines.vh"

module tb_top;
	reg clock = 0;
	reg rst = 1;
	reg psel = 0;
	reg penable = 0;
	reg pwrite = 0;
	reg [11:0] paddr = 0;
	reg [31:0] pwdata = 0;
	reg [2:0] src = 0;
	reg gate_c = 1;
	reg gate_d = 1;
	reg [1:0] ack = 0;
	reg err = 0;
	reg [31:0] rdat = 0;
	wire [31:0] prdata;
	wire pready, pslverr, irq, c_fl, d_fl;
	wire [31:0] fl = {29'h0, irq, d_fl, c_fl};
	integer fails = 0;
	integer compares = 0;
	integer cyc = 0;
	localparam [11:0] a_ct = `DTC_ADDR_CONTROL;
	localparam [11:0] a_md = `DTC_ADDR_MODE;
	localparam [11:0] a_cl = `DTC_ADDR_C_LOW;
	localparam [11:0] a_ch = `DTC_ADDR_C_HIGH;
	localparam [11:0] a_dl = `DTC_ADDR_D_LOW;
	localparam [11:0] a_dh = `DTC_ADDR_D_HIGH;
	localparam [11:0] a_st = `DTC_ADDR_STATUS;
	localparam [11:0] a_mk = `DTC_ADDR_MASK;

	dtc_timer_pair dtc_timer_pair_i (.clock(clock), .rst(rst),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .main_osc_tick(src[0]), .sub_osc_tick(src[1]),
		.timer_c_count_pin(~src[2]), .timer_d_count_pin(~src[2]),
		.timer_c_gate_pin(gate_c), .timer_d_gate_pin(gate_d),
		.timer_c_vector_ack(ack[0]), .timer_d_vector_ack(ack[1]),
		.timer_c_overflow_flag(c_fl), .timer_d_overflow_flag(d_fl),
		.irq(irq));

	always #50 clock = ~clock;

	// Hang guard, far beyond the under one thousand cycles the run needs
	always @(posedge clock) begin
		cyc = cyc + 1;
		if (cyc == 20000) begin
			fails = fails + 1;
			end_of_test;
		end
	end

	task end_of_test;
		if (fails == 0 && compares > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task chk(input [31:0] g, input [31:0] e);
		compares = compares + 1;
		if (g !== e) begin
			fails = fails + 1;
			$display("[ERR] %0t got %h want %h", $time, g, e);
		end
	endtask

	// One APB transfer; read data and error taken at the ready edge
	task xfer(input w, input [11:0] a, input [7:0] d);
		@(posedge clock);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge clock);
		penable <= 1;
		@(posedge clock);
		while (pready !== 1'b1) @(posedge clock);
		rdat = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
	endtask

	task rc(input [11:0] a, input [31:0] e);
		xfer(0, a, 8'h00);
		chk(rdat, e);
	endtask

	// Ticks on source s (0 main, 1 sub, 2 count pin fall), then settle
	task pulse(input integer s, input integer n);
		integer i;
		for (i = 0; i < n; i = i + 1) begin
			@(posedge clock);
			src[s] <= 1;
			repeat (2) @(posedge clock);
			src[s] <= 0;
			repeat (2) @(posedge clock);
		end
		repeat (6) @(posedge clock);
	endtask

	task t_reset;
		rc(a_ct, 0);
		rc(a_md, 0);
		rc(a_st, 0);
		rc(a_mk, 0);
		rc(12'h020, 0);
		chk({31'h0, err}, 1);
		xfer(1, a_md, 8'ha5);
		rc(a_md, 32'ha5);
	endtask

	task t_src(input [7:0] ctl, input [11:0] lo, input integer bad,
		input integer good);
		xfer(1, a_md, 8'h11);
		xfer(1, lo, 8'h10);
		xfer(1, a_ct, ctl);
		rc(a_ct, {24'h0, ctl & 8'hf6});
		pulse(bad, 3);
		rc(lo, 32'h10);
		pulse(good, 3);
		rc(lo, 32'h13);
		xfer(1, a_ct, 0);
		pulse(good, 2);
		rc(lo, 32'h13);
	endtask

	// Gate is moved before a bus transfer so its sync delay has passed
	task t_cnt_gate;
		xfer(1, a_md, 8'h05);
		xfer(1, a_cl, 0);
		xfer(1, a_ct, 8'h10);
		pulse(0, 2);
		rc(a_cl, 0);
		pulse(2, 3);
		rc(a_cl, 3);
		gate_c <= 0;
		xfer(1, a_md, 8'h09);
		pulse(0, 2);
		rc(a_cl, 3);
		gate_c <= 1;
		rc(a_cl, 3);
		pulse(0, 2);
		rc(a_cl, 5);
	endtask

	task t_modes;
		xfer(1, a_ct, 0);
		xfer(1, a_md, 0);
		xfer(1, a_cl, 8'h1f);
		xfer(1, a_ch, 8'hff);
		xfer(1, a_ct, 8'h10);
		pulse(0, 1);
		rc(a_cl, 0);
		rc(a_ch, 0);
		chk(fl, 1);
		xfer(1, a_ct, 0);
		xfer(1, a_md, 1);
		xfer(1, a_cl, 8'hff);
		xfer(1, a_ch, 8'h12);
		xfer(1, a_ct, 8'h10);
		pulse(0, 1);
		rc(a_cl, 0);
		rc(a_ch, 32'h13);
		xfer(1, a_md, 2);
		xfer(1, a_cl, 8'hfe);
		xfer(1, a_ch, 8'h80);
		pulse(0, 3);
		rc(a_cl, 32'h81);
		rc(a_ch, 32'h80);
		chk(fl, 1);
		xfer(1, a_ct, 0);
		xfer(1, a_md, 8'h33);
		xfer(1, a_cl, 5);
		xfer(1, a_ch, 8'h10);
		xfer(1, a_dl, 8'h20);
		xfer(1, a_ct, 8'h50);
		pulse(0, 2);
		rc(a_cl, 7);
		rc(a_ch, 32'h12);
		rc(a_dl, 32'h20);
	endtask

	// Timer D pin events, its rollover flag, then its gate pin
	task t_d_pins;
		xfer(1, a_ct, 0);
		xfer(1, a_md, 8'h50);
		xfer(1, a_dl, 8'hfe);
		xfer(1, a_dh, 8'hff);
		xfer(1, a_ct, 8'h40);
		pulse(0, 2);
		rc(a_dl, 32'hfe);
		pulse(2, 2);
		rc(a_dl, 0);
		chk(fl, 2);
		gate_d <= 0;
		xfer(1, a_md, 8'h90);
		pulse(0, 2);
		rc(a_dl, 0);
		gate_d <= 1;
		rc(a_dh, 0);
		pulse(0, 1);
		rc(a_dl, 1);
	endtask

	// Raise, acknowledge, clear by status read, then mask and unmask
	task t_irq;
		xfer(1, a_ct, 0);
		xfer(0, a_st, 0);
		xfer(1, a_mk, 1);
		xfer(1, a_md, 1);
		xfer(1, a_cl, 8'hff);
		xfer(1, a_ch, 8'hff);
		xfer(1, a_ct, 8'h90);
		pulse(0, 1);
		chk(fl, 7);
		@(posedge clock);
		ack <= 2'b11;
		@(posedge clock);
		ack <= 2'b00;
		@(posedge clock);
		chk(fl, 4);
		rc(a_st, 1);
		@(posedge clock);
		chk(fl, 0);
		xfer(1, a_mk, 0);
		xfer(1, a_cl, 8'hff);
		xfer(1, a_ch, 8'hff);
		pulse(0, 1);
		chk(fl, 1);
		xfer(1, a_mk, 1);
		@(posedge clock);
		chk(fl, 5);
	endtask

	initial begin
		repeat (5) @(posedge clock);
		rst <= 0;
		t_reset;
		t_src(8'h10, a_cl, 1, 0);
		t_src(8'h18, a_cl, 0, 1);
		t_src(8'h40, a_dl, 1, 0);
		t_src(8'h41, a_dl, 0, 1);
		t_cnt_gate;
		t_d_pins;
		t_modes;
		t_irq;
		end_of_test;
	end
endmodule // tb_top

bind dtc_timer_pair dtc_timer_pair_props dtc_timer_pair_props_i (
	.clock(clock), .rst(rst), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .timer_c_vector_ack(timer_c_vector_ack),
	.timer_d_vector_ack(timer_d_vector_ack),
	.timer_c_overflow_flag(timer_c_overflow_flag),
	.timer_d_overflow_flag(timer_d_overflow_flag), .irq(irq));
